// file: dcmc_params.svh
`ifndef DCMC_PARAMS_SVH
`define DCMC_PARAMS_SVH
// Register byte offsets
`define DCMC_OFF_CTL 12'h130
`define DCMC_OFF_STAT 12'h134
`define DCMC_OFF_CLR 12'h138
`define DCMC_OFF_IEN 12'h13c
`define DCMC_OFF_VAL 12'h140
`define DCMC_OFF_ADR 12'h144
// Control field positions
`define DCMC_B_ON 0
`define DCMC_B_DIRE 2
`define DCMC_B_DIR 3
`define DCMC_B_PC 5
`define DCMC_B_NDAT 6
`define DCMC_CTL_RST 8'h00
`define DCMC_CTL_MASK 8'h6d
// Status bits
`define DCMC_S_MATCH 0
`define DCMC_S_BLOCK 1
`define DCMC_RESP_OK 2'b00
`define DCMC_RESP_ERR 2'b10
`endif

// file: dcmc_pkg.sv
package dcmc_pkg;
  // Monitored bus cycle
  typedef struct packed {
    logic valid;
    logic pc_cycle;
    logic rd_nwr;
    logic [23:0] addr;
    logic [31:0] data;
  } dcmc_bus_t;
  typedef enum logic [1:0] {DCMC_W_IDLE, DCMC_W_RESP} dcmc_wst_t;
  typedef enum logic [1:0] {DCMC_R_IDLE, DCMC_R_RESP} dcmc_rst_t;
  typedef struct packed {
    dcmc_wst_t wst;
    logic aw_got;
    logic w_got;
    logic [11:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    dcmc_rst_t rst;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] ctl;
    logic [31:0] cval;
    logic [23:0] cadr;
    logic [1:0] stat;
    logic [1:0] ien;
    logic hit;
    logic irq;
  } dcmc_state_t;
endpackage : dcmc_pkg

// file: dcmc_top.sv
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "dcmc_params.svh"
module dcmc_top (
  input wire logic MCLK, // System clock
  input wire logic NRST, // Async reset, active low
  input wire dcmc_pkg::dcmc_bus_t BUS, // Monitored core cycle
  input wire logic ARMED, // Debug module armed
  input wire logic TRACE_ACTIVE, // Trace-active flag
  input wire logic [11:0] AWADDR, // Write address
  input wire logic AWVALID, // Write address valid
  output logic AWREADY, // Write address ready
  input wire logic [31:0] WDATA, // Write data
  input wire logic [3:0] WSTRB, // Write strobes
  input wire logic WVALID, // Write data valid
  output logic WREADY, // Write data ready
  output logic [1:0] BRESP, // Write response
  output logic BVALID, // Write response valid
  input wire logic BREADY, // Write response ready
  input wire logic [11:0] ARADDR, // Read address
  input wire logic ARVALID, // Read address valid
  output logic ARREADY, // Read address ready
  output logic [31:0] RDATA, // Read data
  output logic [1:0] RRESP, // Read response
  output logic RVALID, // Read data valid
  input wire logic RREADY, // Read data ready
  output logic MATCH, // Registered comparator match
  output logic IRQ // Level interrupt
);
  import dcmc_pkg::*;

  dcmc_state_t s_r;
  dcmc_state_t s_nxt;
  logic rst_n;
  logic [1:0] rst_sync_r;
  logic hit_c;
  logic addr_ok;
  logic data_ok;
  logic dir_ok;
  logic wr_fire;
  logic wr_blocked;

  assign rst_n = rst_sync_r[1];

  // Reads back one word per offset, zero elsewhere
  function automatic logic [31:0] rd_word(input dcmc_state_t s, input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      `DCMC_OFF_CTL: v = {24'h000000, s.ctl};
      `DCMC_OFF_STAT: v = {30'h0000_0000, s.stat};
      `DCMC_OFF_IEN: v = {30'h0000_0000, s.ien};
      `DCMC_OFF_VAL: v = s.cval;
      `DCMC_OFF_ADR: v = {8'h00, s.cadr};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : rd_word

  // Known register offsets
  function automatic logic mapped(input logic [11:0] a);
    return (a == `DCMC_OFF_CTL) || (a == `DCMC_OFF_STAT) || (a == `DCMC_OFF_CLR) ||
           (a == `DCMC_OFF_IEN) || (a == `DCMC_OFF_VAL) || (a == `DCMC_OFF_ADR);
  endfunction : mapped

  // Byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ------------------------------------------------------------
  // Comparator
  // ------------------------------------------------------------
  // Address, data and direction qualifiers
  always_comb begin
    addr_ok = (BUS.addr == s_r.cadr) && (BUS.pc_cycle == s_r.ctl[`DCMC_B_PC]);
    data_ok = s_r.ctl[`DCMC_B_NDAT] ? (BUS.data != s_r.cval) : (BUS.data == s_r.cval);
    dir_ok = !s_r.ctl[`DCMC_B_DIRE] || (BUS.rd_nwr == s_r.ctl[`DCMC_B_DIR]);
    // PC compare ignores data and direction
    if (s_r.ctl[`DCMC_B_PC]) begin
      hit_c = addr_ok;
    end else begin
      hit_c = addr_ok && data_ok && dir_ok;
    end
    hit_c = hit_c && BUS.valid && s_r.ctl[`DCMC_B_ON];
  end

  // ------------------------------------------------------------
  // Bus slave and state update
  // ------------------------------------------------------------
  assign wr_fire = (s_r.wst == DCMC_W_IDLE) && s_r.aw_got && s_r.w_got;
  assign wr_blocked = ARMED || TRACE_ACTIVE;

  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.hit = hit_c;
    if (s_r.wst == DCMC_W_IDLE) begin
      if (AWVALID && !s_r.aw_got) begin
        s_nxt.aw_got = 1'b1;
        s_nxt.waddr = AWADDR;
      end
      if (WVALID && !s_r.w_got) begin
        s_nxt.w_got = 1'b1;
        s_nxt.wdata = WDATA;
        s_nxt.wstrb = WSTRB;
      end
    end
    // Events set status; set wins over clear
    if (wr_fire) begin
      s_nxt.wst = DCMC_W_RESP;
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bresp = mapped(s_r.waddr) ? `DCMC_RESP_OK : `DCMC_RESP_ERR;
      unique case (s_r.waddr)
        `DCMC_OFF_CTL: begin
          if (!wr_blocked && s_r.wstrb[0]) begin
            s_nxt.ctl = s_r.wdata[7:0] & `DCMC_CTL_MASK;
          end else if (wr_blocked) begin
            s_nxt.stat[`DCMC_S_BLOCK] = 1'b1;
          end
        end
        `DCMC_OFF_CLR: if (s_r.wstrb[0]) s_nxt.stat = s_r.stat & ~s_r.wdata[1:0];
        `DCMC_OFF_IEN: if (s_r.wstrb[0]) s_nxt.ien = s_r.wdata[1:0];
        `DCMC_OFF_VAL: s_nxt.cval = merge(s_r.cval, s_r.wdata, s_r.wstrb);
        `DCMC_OFF_ADR: s_nxt.cadr = 24'(merge({8'h00, s_r.cadr}, s_r.wdata, s_r.wstrb));
        default: ;
      endcase
      if (s_r.waddr == `DCMC_OFF_CTL && wr_blocked) begin
        s_nxt.stat[`DCMC_S_BLOCK] = 1'b1;
      end
    end else if (s_r.wst == DCMC_W_RESP && BREADY) begin
      s_nxt.wst = DCMC_W_IDLE;
    end
    if (hit_c) begin
      s_nxt.stat[`DCMC_S_MATCH] = 1'b1;
    end
    s_nxt.irq = |(s_nxt.stat & s_nxt.ien);
    // Read channel
    if (s_r.rst == DCMC_R_IDLE) begin
      if (ARVALID) begin
        s_nxt.rst = DCMC_R_RESP;
        s_nxt.rdata = rd_word(s_r, ARADDR);
        s_nxt.rresp = mapped(ARADDR) ? `DCMC_RESP_OK : `DCMC_RESP_ERR;
      end
    end else if (RREADY) begin
      s_nxt.rst = DCMC_R_IDLE;
    end
  end

  // ------------------------------------------------------------
  // Reset synchroniser
  // ------------------------------------------------------------
  // Kept out of the state struct since it alone runs on the raw reset
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  // Remaining state on the synchronised reset
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      s_r.wst <= DCMC_W_IDLE;
      s_r.aw_got <= 1'b0;
      s_r.w_got <= 1'b0;
      s_r.waddr <= 12'h000;
      s_r.wdata <= 32'h0000_0000;
      s_r.wstrb <= 4'h0;
      s_r.bresp <= `DCMC_RESP_OK;
      s_r.rst <= DCMC_R_IDLE;
      s_r.rdata <= 32'h0000_0000;
      s_r.rresp <= `DCMC_RESP_OK;
      s_r.ctl <= `DCMC_CTL_RST;
      s_r.cval <= 32'h0000_0000;
      s_r.cadr <= 24'h000000;
      s_r.stat <= 2'b00;
      s_r.ien <= 2'b00;
      s_r.hit <= 1'b0;
      s_r.irq <= 1'b0;
    end else begin
      s_r.wst <= s_nxt.wst;
      s_r.aw_got <= s_nxt.aw_got;
      s_r.w_got <= s_nxt.w_got;
      s_r.waddr <= s_nxt.waddr;
      s_r.wdata <= s_nxt.wdata;
      s_r.wstrb <= s_nxt.wstrb;
      s_r.bresp <= s_nxt.bresp;
      s_r.rst <= s_nxt.rst;
      s_r.rdata <= s_nxt.rdata;
      s_r.rresp <= s_nxt.rresp;
      s_r.ctl <= s_nxt.ctl;
      s_r.cval <= s_nxt.cval;
      s_r.cadr <= s_nxt.cadr;
      s_r.stat <= s_nxt.stat;
      s_r.ien <= s_nxt.ien;
      s_r.hit <= s_nxt.hit;
      s_r.irq <= s_nxt.irq;
    end
  end

  // Outputs straight from state flops
  assign AWREADY = (s_r.wst == DCMC_W_IDLE) && !s_r.aw_got && rst_n;
  assign WREADY = (s_r.wst == DCMC_W_IDLE) && !s_r.w_got && rst_n;
  assign BVALID = (s_r.wst == DCMC_W_RESP);
  assign BRESP = s_r.bresp;
  assign ARREADY = (s_r.rst == DCMC_R_IDLE) && rst_n;
  assign RVALID = (s_r.rst == DCMC_R_RESP);
  assign RDATA = s_r.rdata;
  assign RRESP = s_r.rresp;
  assign MATCH = s_r.hit;
  assign IRQ = s_r.irq;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  // off never matches
  a_off_no_match: assert property (@(posedge MCLK) disable iff (!rst_n)
    !s_r.ctl[`DCMC_B_ON] |=> !MATCH) else $error("Match while comparator off");
  a_blocked_ctl_hold: assert property (@(posedge MCLK) disable iff (!rst_n)
    (wr_fire && wr_blocked) |=> $stable(s_r.ctl)) else $error("Control changed while blocked");
  a_blocked_flag: assert property (@(posedge MCLK) disable iff (!rst_n)
    (wr_fire && wr_blocked && s_r.waddr == `DCMC_OFF_CTL) |=> s_r.stat[`DCMC_S_BLOCK])
    else $error("Blocked control write not flagged");
  a_free_ctl_write: assert property (@(posedge MCLK) disable iff (!rst_n)
    (wr_fire && !wr_blocked && s_r.waddr == `DCMC_OFF_CTL && s_r.wstrb[0])
    |=> s_r.ctl == ($past(s_r.wdata[7:0]) & `DCMC_CTL_MASK)) else $error("Control write lost");
  a_pc_ignores_data: assert property (@(posedge MCLK) disable iff (!rst_n)
    (s_r.ctl[`DCMC_B_ON] && s_r.ctl[`DCMC_B_PC] && BUS.valid && addr_ok) |=> MATCH)
    else $error("PC match missed");
  a_addr_miss: assert property (@(posedge MCLK) disable iff (!rst_n)
    !addr_ok |=> !MATCH) else $error("Match without address hit");
  a_pc_cycle_kind: assert property (@(posedge MCLK) disable iff (!rst_n)
    (s_r.ctl[`DCMC_B_PC] && !BUS.pc_cycle) |=> !MATCH)
    else $error("PC compare matched a data cycle");
  a_pc_data_free: assert property (@(posedge MCLK) disable iff (!rst_n)
    (s_r.ctl[`DCMC_B_ON] && s_r.ctl[`DCMC_B_PC] && !s_r.ctl[`DCMC_B_NDAT] && BUS.valid &&
     addr_ok && BUS.data != s_r.cval) |=> MATCH) else $error("PC match depends on data");
  a_pc_dir_free: assert property (@(posedge MCLK) disable iff (!rst_n)
    (s_r.ctl[`DCMC_B_ON] && s_r.ctl[`DCMC_B_PC] && s_r.ctl[`DCMC_B_DIRE] && BUS.valid &&
     addr_ok && BUS.rd_nwr != s_r.ctl[`DCMC_B_DIR]) |=> MATCH)
    else $error("PC match depends on direction");
  a_dir_unused: assert property (@(posedge MCLK) disable iff (!rst_n)
    (s_r.ctl[`DCMC_B_ON] && !s_r.ctl[`DCMC_B_PC] && !s_r.ctl[`DCMC_B_DIRE] && BUS.valid &&
     addr_ok && data_ok) |=> MATCH) else $error("Direction used while disabled");
  a_write_match: assert property (@(posedge MCLK) disable iff (!rst_n)
    (s_r.ctl[`DCMC_B_ON] && !s_r.ctl[`DCMC_B_PC] && s_r.ctl[`DCMC_B_DIRE] &&
     !s_r.ctl[`DCMC_B_DIR] && !BUS.rd_nwr && BUS.valid && addr_ok && data_ok) |=> MATCH)
    else $error("Write match missed");
  a_read_sel_write: assert property (@(posedge MCLK) disable iff (!rst_n)
    (!s_r.ctl[`DCMC_B_PC] && s_r.ctl[`DCMC_B_DIRE] && s_r.ctl[`DCMC_B_DIR] && !BUS.rd_nwr)
    |=> !MATCH) else $error("Write matched with read selected");
  a_write_dir: assert property (@(posedge MCLK) disable iff (!rst_n)
    (!s_r.ctl[`DCMC_B_PC] && s_r.ctl[`DCMC_B_DIRE] && !s_r.ctl[`DCMC_B_DIR] && BUS.rd_nwr)
    |=> !MATCH) else $error("Read matched with write selected");
  a_read_dir: assert property (@(posedge MCLK) disable iff (!rst_n)
    (s_r.ctl[`DCMC_B_ON] && !s_r.ctl[`DCMC_B_PC] && s_r.ctl[`DCMC_B_DIRE] &&
     s_r.ctl[`DCMC_B_DIR] && BUS.rd_nwr && BUS.valid && addr_ok && data_ok) |=> MATCH)
    else $error("Read match missed");
  a_data_sense: assert property (@(posedge MCLK) disable iff (!rst_n)
    (!s_r.ctl[`DCMC_B_PC] && s_r.ctl[`DCMC_B_NDAT] && BUS.data == s_r.cval) |=> !MATCH)
    else $error("Equal data matched in mismatch mode");
  a_data_equal: assert property (@(posedge MCLK) disable iff (!rst_n)
    (!s_r.ctl[`DCMC_B_PC] && !s_r.ctl[`DCMC_B_NDAT] && BUS.data != s_r.cval) |=> !MATCH)
    else $error("Unequal data matched in equality mode");
  // Interrupt follows enabled status
  a_irq_level: assert property (@(posedge MCLK) disable iff (!rst_n)
    MATCH && s_r.ien[`DCMC_S_MATCH] |-> ##[0:1] IRQ) else $error("Interrupt not raised");
endmodule : dcmc_top

// file: dcmc_core_model.sv
`timescale 1ns/1ns
module dcmc_core_model (
  input wire logic clk, // System clock
  output dcmc_pkg::dcmc_bus_t bus // Monitored core cycle
);
  import dcmc_pkg::*;
  // Quiet bus until the first cycle
  initial bus = '0;
  // One bus cycle, then idle lines show the inverse so stale values never match
  task automatic cycle(input logic pc, input logic rd, input logic [23:0] a,
      input logic [31:0] d);
    @(posedge clk);
    bus <= '{valid: 1'b1, pc_cycle: pc, rd_nwr: rd, addr: a, data: d};
    @(posedge clk);
    bus <= '{valid: 1'b0, pc_cycle: ~pc, rd_nwr: ~rd, addr: ~a, data: ~d};
  endtask : cycle
endmodule : dcmc_core_model

// file: debug_comparator_match_control_tb.sv
`timescale 1ns/1ns
`include "dcmc_params.svh"
module debug_comparator_match_control_tb;
  import dcmc_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam logic [23:0] CA = 24'h123456;
  localparam logic [31:0] CV = 32'ha5a5a5a5;
  logic mclk = 1'b0, nrst = 1'b0, armed = 1'b0, trace_active = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, match, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  dcmc_bus_t bus;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  // Clock at 100 MHz
  always #5 mclk = ~mclk;
  dcmc_core_model core (.clk(mclk), .bus(bus));
  dcmc_top dut (.MCLK(mclk), .NRST(nrst), .BUS(bus), .ARMED(armed),
    .TRACE_ACTIVE(trace_active), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .MATCH(match), .IRQ(irq));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  // Write one word, address and data offered together
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      ad |= awready;
      wd |= wready;
    end while (!(ad && wd));
    do @(posedge mclk); while (!bvalid);
    bready <= 1'b0;
    chk(bresp, er, "write response");
  endtask : axw
  // Read one word and compare data and response
  task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk); while (!rvalid);
    rready <= 1'b0;
    chk(rresp, er, "read response");
    chk(rdata, ed, "read data");
  endtask : axr
  task automatic t_regs;
    axr(`DCMC_OFF_CTL, 32'h0, `DCMC_RESP_OK);
    axw(`DCMC_OFF_CTL, 32'hff, `DCMC_RESP_OK);
    axr(`DCMC_OFF_CTL, 32'h6d, `DCMC_RESP_OK);
    axr(12'h200, 32'h0, `DCMC_RESP_ERR);
    axw(12'h204, 32'h1, `DCMC_RESP_ERR);
    axw(`DCMC_OFF_ADR, {8'h0, CA}, `DCMC_RESP_OK);
    axw(`DCMC_OFF_VAL, CV, `DCMC_RESP_OK);
    axr(`DCMC_OFF_ADR, {8'h0, CA}, `DCMC_RESP_OK);
    $display("test regs done");
  endtask : t_regs
  // Control writes are refused while armed or tracing
  task automatic t_block;
    armed <= 1'b1;
    axw(`DCMC_OFF_CTL, 32'h01, `DCMC_RESP_OK);
    armed <= 1'b0;
    trace_active <= 1'b1;
    axw(`DCMC_OFF_CTL, 32'h41, `DCMC_RESP_OK);
    trace_active <= 1'b0;
    axr(`DCMC_OFF_CTL, 32'h6d, `DCMC_RESP_OK);
    axr(`DCMC_OFF_STAT, 32'h2, `DCMC_RESP_OK);
    axw(`DCMC_OFF_CLR, 32'h3, `DCMC_RESP_OK);
    axr(`DCMC_OFF_STAT, 32'h0, `DCMC_RESP_OK);
    $display("test block done");
  endtask : t_block
  // Program control, run one bus cycle, check the match a cycle later
  task automatic mc(input logic [7:0] c, input logic pc, input logic rd,
      input logic [23:0] a, input logic [31:0] d, input logic e);
    axw(`DCMC_OFF_CTL, {24'h0, c}, `DCMC_RESP_OK);
    core.cycle(pc, rd, a, d);
    #1;
    chk(match, e, "match");
  endtask : mc
  task automatic t_match;
    mc(8'h00, 1'b0, 1'b0, CA, CV, 1'b0);
    mc(8'h00, 1'b1, 1'b0, CA, CV, 1'b0);
    mc(8'h01, 1'b0, 1'b0, CA, CV, 1'b1);
    mc(8'h01, 1'b0, 1'b1, CA, ~CV, 1'b0);
    mc(8'h41, 1'b0, 1'b0, CA, ~CV, 1'b1);
    mc(8'h41, 1'b0, 1'b0, CA, CV, 1'b0);
    mc(8'h01, 1'b0, 1'b0, ~CA, CV, 1'b0);
    mc(8'h21, 1'b1, 1'b0, CA, ~CV, 1'b1);
    mc(8'h61, 1'b1, 1'b1, CA, CV, 1'b1);
    mc(8'h2d, 1'b1, 1'b0, CA, ~CV, 1'b1);
    mc(8'h21, 1'b0, 1'b0, CA, CV, 1'b0);
    mc(8'h01, 1'b1, 1'b0, CA, CV, 1'b0);
    mc(8'h05, 1'b0, 1'b0, CA, CV, 1'b1);
    mc(8'h05, 1'b0, 1'b1, CA, CV, 1'b0);
    mc(8'h0d, 1'b0, 1'b1, CA, CV, 1'b1);
    mc(8'h0d, 1'b0, 1'b0, CA, CV, 1'b0);
    mc(8'h09, 1'b0, 1'b0, CA, CV, 1'b1);
    mc(8'h01, 1'b0, 1'b1, CA, CV, 1'b1);
    $display("test match done");
  endtask : t_match
  // Sticky match status drives the interrupt through the enable mask
  task automatic t_irq;
    axw(`DCMC_OFF_IEN, 32'h0, `DCMC_RESP_OK);
    axr(`DCMC_OFF_STAT, 32'h1, `DCMC_RESP_OK);
    chk(irq, 1'b0, "irq masked");
    axw(`DCMC_OFF_IEN, 32'h1, `DCMC_RESP_OK);
    axr(`DCMC_OFF_IEN, 32'h1, `DCMC_RESP_OK);
    chk(irq, 1'b1, "irq raised");
    axw(`DCMC_OFF_CLR, 32'h1, `DCMC_RESP_OK);
    axr(`DCMC_OFF_STAT, 32'h0, `DCMC_RESP_OK);
    chk(irq, 1'b0, "irq cleared");
    $display("test irq done");
  endtask : t_irq
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      wrap_up;
    end
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs;
    t_block;
    t_match;
    t_irq;
    wrap_up;
  end
endmodule : debug_comparator_match_control_tb
